// [hw/azt_pkg.sv]
// Package with register map, widths and arithmetic helpers for the zero-g trim block
package azt_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int AZT_ADDR_W   = 8;
   localparam int AZT_DATA_W   = 8;
   localparam int AZT_TRIM_W   = 8;
   localparam int AZT_SAMPLE_W = 14;   // Axis sample in 1 mg per count
   localparam int AZT_SUM_W    = 16;   // Headroom for sample plus trim

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets and reset values
   localparam logic [AZT_ADDR_W-1:0] AZT_X_TRIM_ADDR = 8'h2F;
   localparam logic [AZT_ADDR_W-1:0] AZT_Y_TRIM_ADDR = 8'h30;
   localparam logic [AZT_ADDR_W-1:0] AZT_Z_TRIM_ADDR = 8'h31;
   localparam logic [AZT_TRIM_W-1:0] AZT_TRIM_RST    = 8'h00;
   localparam logic [AZT_DATA_W-1:0] AZT_UNMAPPED_RD = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Scaling and limits
   localparam int AZT_TRIM_MG_PER_COUNT = 2;
   localparam logic signed [AZT_SAMPLE_W-1:0] AZT_SAMPLE_MAX = 14'h1FFF;
   localparam logic signed [AZT_SAMPLE_W-1:0] AZT_SAMPLE_MIN = 14'h2000;

   // Axis selector for the register decode
   typedef enum logic [1:0] {
      AZT_AXIS_X,
      AZT_AXIS_Y,
      AZT_AXIS_Z,
      AZT_AXIS_NONE
   } azt_axis_t;

   // Trim code to mg: sign extend and double, 2 mg per count
   function automatic logic signed [AZT_SUM_W-1:0] azt_trim_mg(
      input logic [AZT_TRIM_W-1:0] code);
      azt_trim_mg = {{(AZT_SUM_W-AZT_TRIM_W-1){code[AZT_TRIM_W-1]}}, code, 1'b0};
   endfunction

   // Register address to axis
   function automatic azt_axis_t azt_decode(input logic [AZT_ADDR_W-1:0] addr);
      case (addr)
         AZT_X_TRIM_ADDR: azt_decode = AZT_AXIS_X;
         AZT_Y_TRIM_ADDR: azt_decode = AZT_AXIS_Y;
         AZT_Z_TRIM_ADDR: azt_decode = AZT_AXIS_Z;
         default:         azt_decode = AZT_AXIS_NONE;
      endcase
   endfunction

   // Clamp a wide sum to the sample range
   function automatic logic signed [AZT_SAMPLE_W-1:0] azt_clamp(
      input logic signed [AZT_SUM_W-1:0] v);
      if (v > AZT_SUM_W'(AZT_SAMPLE_MAX)) begin
         azt_clamp = AZT_SAMPLE_MAX;
      end else if (v < AZT_SUM_W'(AZT_SAMPLE_MIN)) begin
         azt_clamp = AZT_SAMPLE_MIN;
      end else begin
         azt_clamp = v[AZT_SAMPLE_W-1:0];
      end
   endfunction

endpackage

// [hw/azt_axis_corrector.sv]
// One axis: adds the scaled trim to each new sample and holds the result
module azt_axis_corrector (
   // Clock and reset
   input  wire logic                               clk_sys,
   input  wire logic                               rst,
   // Sample in
   input  wire logic                               sample_valid,
   input  wire logic signed [azt_pkg::AZT_SAMPLE_W-1:0] sample_raw,
   input  wire logic [azt_pkg::AZT_TRIM_W-1:0]     trim,
   // Corrected sample out
   output logic signed [azt_pkg::AZT_SAMPLE_W-1:0] corrected
);
   import azt_pkg::*;

   logic signed [AZT_SUM_W-1:0] sum_next;

   // Sum in wide form so no trim within range is clipped
   always_comb begin
      sum_next = AZT_SUM_W'(sample_raw) + azt_trim_mg(trim);
   end

   // Store corrected sample for readout
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         corrected <= '0;
      end else if (sample_valid) begin
         corrected <= azt_clamp(sum_next);
      end
   end

endmodule

// [hw/azt_offset_trim.sv]
// Zero-g offset trim register bank with per-axis sample correction
module azt_offset_trim (
   // Clock and reset
   input  wire logic                                   clk_sys,
   input  wire logic                                   rst,
   // Register port from the serial control interface
   input  wire logic [azt_pkg::AZT_ADDR_W-1:0]         reg_addr,
   input  wire logic                                   reg_wr,
   input  wire logic [azt_pkg::AZT_DATA_W-1:0]         reg_wdata,
   input  wire logic                                   reg_rd,
   output logic [azt_pkg::AZT_DATA_W-1:0]              reg_rdata,
   output logic                                        reg_rdata_valid,
   // Raw samples in 1 mg per count
   input  wire logic                                   sample_valid,
   input  wire logic signed [azt_pkg::AZT_SAMPLE_W-1:0] sample_x,
   input  wire logic signed [azt_pkg::AZT_SAMPLE_W-1:0] sample_y,
   input  wire logic signed [azt_pkg::AZT_SAMPLE_W-1:0] sample_z,
   // Corrected samples
   output logic signed [azt_pkg::AZT_SAMPLE_W-1:0]     out_x,
   output logic signed [azt_pkg::AZT_SAMPLE_W-1:0]     out_y,
   output logic signed [azt_pkg::AZT_SAMPLE_W-1:0]     out_z,
   output logic                                        out_valid
);
   import azt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Trim registers and decode

   logic [AZT_TRIM_W-1:0] x_trim_reg;
   logic [AZT_TRIM_W-1:0] y_trim_reg;
   logic [AZT_TRIM_W-1:0] z_trim_reg;
   azt_axis_t             axis_sel;

   // Address to axis
   always_comb begin
      axis_sel = azt_decode(reg_addr);
   end

   // Host writes; unmapped writes are dropped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         x_trim_reg <= AZT_TRIM_RST;
         y_trim_reg <= AZT_TRIM_RST;
         z_trim_reg <= AZT_TRIM_RST;
      end else if (reg_wr) begin
         case (axis_sel)
            AZT_AXIS_X: x_trim_reg <= reg_wdata;
            AZT_AXIS_Y: y_trim_reg <= reg_wdata;
            AZT_AXIS_Z: z_trim_reg <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: data one cycle after the strobe

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata       <= AZT_UNMAPPED_RD;
         reg_rdata_valid <= 1'b0;
      end else begin
         reg_rdata_valid <= reg_rd;
         if (reg_rd) begin
            case (axis_sel)
               AZT_AXIS_X: reg_rdata <= x_trim_reg;
               AZT_AXIS_Y: reg_rdata <= y_trim_reg;
               AZT_AXIS_Z: reg_rdata <= z_trim_reg;
               default:    reg_rdata <= AZT_UNMAPPED_RD;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-axis correction

   azt_axis_corrector u_corr_x (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .sample_valid (sample_valid),
      .sample_raw   (sample_x),
      .trim         (x_trim_reg),
      .corrected    (out_x)
   );

   azt_axis_corrector u_corr_y (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .sample_valid (sample_valid),
      .sample_raw   (sample_y),
      .trim         (y_trim_reg),
      .corrected    (out_y)
   );

   azt_axis_corrector u_corr_z (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .sample_valid (sample_valid),
      .sample_raw   (sample_z),
      .trim         (z_trim_reg),
      .corrected    (out_z)
   );

   // Marks a fresh set of corrected samples
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= sample_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   // Plain model of one axis sum, kept apart from the corrector's own helper
   function automatic logic signed [AZT_SUM_W-1:0] chk_sum(
      input logic signed [AZT_SAMPLE_W-1:0] s,
      input logic [AZT_TRIM_W-1:0]          t);
      chk_sum = AZT_SUM_W'(s) + AZT_SUM_W'($signed(t)) * AZT_SUM_W'(AZT_TRIM_MG_PER_COUNT);
   endfunction

   // Expected results in wide form, for the checks only
   logic signed [AZT_SUM_W-1:0] exp_x_sum;
   logic signed [AZT_SUM_W-1:0] exp_y_sum;
   logic signed [AZT_SUM_W-1:0] exp_z_sum;
   always_comb begin
      exp_x_sum = chk_sum(sample_x, x_trim_reg);
      exp_y_sum = chk_sum(sample_y, y_trim_reg);
      exp_z_sum = chk_sum(sample_z, z_trim_reg);
   end

   reset_trims_zero_a: assert property (
      @(posedge clk_sys) $fell(rst) |->
         (x_trim_reg == 8'h00) && (y_trim_reg == 8'h00) && (z_trim_reg == 8'h00))
      else $error("trims not zero after reset");

   write_x_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr == 8'h2F |=> x_trim_reg == $past(reg_wdata))
      else $error("x trim write lost");

   write_z_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr == 8'h31 |=> z_trim_reg == $past(reg_wdata) && $stable(y_trim_reg))
      else $error("z trim write wrong");

   write_y_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr == AZT_Y_TRIM_ADDR |=>
         y_trim_reg == $past(reg_wdata) && $stable(x_trim_reg))
      else $error("y trim write wrong");

   // Valid in the second cycle reflects a strobe in the first, not the second
   read_y_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_rd && !reg_wr && reg_addr == AZT_Y_TRIM_ADDR |=>
         reg_rdata_valid && reg_rdata == $past(y_trim_reg) ##1 !reg_rdata_valid || $past(reg_rd))
      else $error("y trim readback wrong");

   read_x_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == AZT_X_TRIM_ADDR |=> reg_rdata == $past(x_trim_reg))
      else $error("x trim readback wrong");

   read_z_trim_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == AZT_Z_TRIM_ADDR |=> reg_rdata == $past(z_trim_reg))
      else $error("z trim readback wrong");

   read_unmapped_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr < 8'h2F || reg_addr > 8'h31) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   // Writes outside the three trims leave every trim alone
   unmapped_write_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && (reg_addr < AZT_X_TRIM_ADDR || reg_addr > AZT_Z_TRIM_ADDR) |=>
         $stable(x_trim_reg) && $stable(y_trim_reg) && $stable(z_trim_reg))
      else $error("unmapped write changed a trim");

   // Read valid is exactly one cycle behind the strobe
   rdata_valid_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> reg_rdata_valid == $past(reg_rd))
      else $error("read valid timing wrong");

   x_correction_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sample_valid && exp_x_sum <= 16'sd8191 && exp_x_sum >= -16'sd8192 |=>
         AZT_SUM_W'(out_x) == $past(exp_x_sum) && out_valid)
      else $error("x correction wrong");

   y_correction_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sample_valid && exp_y_sum <= 16'sd8191 && exp_y_sum >= -16'sd8192 |=>
         AZT_SUM_W'(out_y) == $past(exp_y_sum))
      else $error("y correction wrong");

   z_correction_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sample_valid && exp_z_sum <= 16'sd8191 && exp_z_sum >= -16'sd8192 |=>
         AZT_SUM_W'(out_z) == $past(exp_z_sum))
      else $error("z correction wrong");

   // Output valid is exactly one cycle behind the sample strobe
   out_valid_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> out_valid == $past(sample_valid))
      else $error("output valid timing wrong");

   trim_span_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sample_valid && sample_y == 14'h0000 |=>
         out_y >= -14'sd256 && out_y <= 14'sd254 && out_y[0] == 1'b0)
      else $error("y trim outside span");

   trim_weight_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sample_valid && sample_z == 14'h0000 && z_trim_reg == 8'h80 |=> out_z == -14'sd256)
      else $error("z trim weight wrong");

   cover_write_x_c: cover property (
      @(posedge clk_sys) disable iff (rst) reg_wr && reg_addr == 8'h2F);

   cover_read_z_c: cover property (
      @(posedge clk_sys) disable iff (rst) reg_rd && reg_addr == 8'h31 ##1 reg_rdata != 8'h00);

   cover_neg_trim_c: cover property (
      @(posedge clk_sys) disable iff (rst) sample_valid && x_trim_reg[7]);

   cover_clamp_c: cover property (
      @(posedge clk_sys) disable iff (rst) sample_valid && exp_x_sum > 16'sd8191);

   cover_unmapped_wr_c: cover property (
      @(posedge clk_sys) disable iff (rst) reg_wr && reg_addr > AZT_Z_TRIM_ADDR);

endmodule

// [verification/azt_host_model.sv]
// Host model: drives register writes and reads on the trim port
module azt_host_model (
   // Clock
   input  wire logic                            clk_sys,
   // Register port
   output logic [azt_pkg::AZT_ADDR_W-1:0]       reg_addr,
   output logic                                 reg_wr,
   output logic [azt_pkg::AZT_DATA_W-1:0]       reg_wdata,
   output logic                                 reg_rd,
   input  wire logic [azt_pkg::AZT_DATA_W-1:0]  reg_rdata,
   input  wire logic                            reg_rdata_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   import azt_pkg::*;

   ////////////////////////////////////////////////////////////
   // Quiet bus at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Released lines show a changed pattern, not the last value
   task automatic idle();
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask

   // One write, taken at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clk_sys);
      #1;
      idle();
   endtask

   // One read; answer sampled in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk_sys);
      #1;
      idle();
      v = reg_rdata_valid;
      d = reg_rdata;
   endtask
endmodule

// [verification/azt_offset_trim_tb.sv]
// Testbench for the trim bank: register access and sample correction
module azt_offset_trim_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import azt_pkg::*;

   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic [7:0]         reg_addr, reg_wdata, reg_rdata, rv;
   logic               reg_wr, reg_rd, reg_rdata_valid, out_valid, vv;
   logic               sample_valid = 1'b0;
   logic signed [13:0] sample_x = '0, sample_y = '0, sample_z = '0;
   logic signed [13:0] out_x, out_y, out_z;
   logic [7:0]         trim [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0]         ct [4] = '{8'h80, 8'h7F, 8'h80, 8'h7F};
   logic signed [13:0] cs [4] = '{-14'sd8192, 14'sd8191, 14'sd0, 14'sd0};
   logic [31:0]        seed = 32'd92, r;
   int                 fails = 0, samples_checked = 0, cyc = 0;

   azt_offset_trim i_azt_offset_trim (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rdata_valid(reg_rdata_valid), .sample_valid(sample_valid), .sample_x(sample_x),
      .sample_y(sample_y), .sample_z(sample_z), .out_x(out_x), .out_y(out_y),
      .out_z(out_z), .out_valid(out_valid));
   azt_host_model i_azt_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rdata_valid(reg_rdata_valid));

   ////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         tally_and_finish();
      end
   end

   // Xorshift source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Sample plus 2 mg per signed count, clamped to 14 bits
   function automatic logic signed [13:0] exp_out(input logic signed [13:0] s, input logic [7:0] t);
      int v;
      v = int'(s) + 2 * int'($signed(t));
      if (v > 8191) v = 8191;
      if (v < -8192) v = -8192;
      return 14'(v);
   endfunction

   // Compare and count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // Register read with expected data
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_azt_host_model.rd(a, rv, vv);
      chk("rdata_valid", 16'h0001, 16'(vv));
      chk("reg_rdata", 16'(e), 16'(rv));
      chk("out_valid_idle", 16'h0000, 16'(out_valid));
   endtask

   // One sample set, outputs checked a cycle later
   task automatic smp(input logic signed [13:0] x, input logic signed [13:0] y,
                      input logic signed [13:0] z);
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b1;
      sample_x = x;
      sample_y = y;
      sample_z = z;
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b0;
      sample_x = ~x;
      chk("out_valid", 16'h0001, 16'(out_valid));
      chk("rdata_valid_idle", 16'h0000, 16'(reg_rdata_valid));
      chk("out_x", 16'(exp_out(x, trim[0])), 16'(out_x));
      chk("out_y", 16'(exp_out(y, trim[1])), 16'(out_y));
      chk("out_z", 16'(exp_out(z, trim[2])), 16'(out_z));
   endtask

   task automatic tally_and_finish();
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      for (int i = 0; i < 3; i++) rchk(AZT_X_TRIM_ADDR + 8'(i), 8'h00);
      smp(14'sd100, -14'sd100, 14'sd0);
      rchk(8'h2E, 8'h00);
      for (int n = 0; n < 40; n++) begin
         for (int i = 0; i < 3; i++) begin
            r = xs();
            trim[i] = (n < 4) ? ct[n] : r[7:0];
            i_azt_host_model.wr(AZT_X_TRIM_ADDR + 8'(i), trim[i]);
         end
         r = xs();
         i_azt_host_model.wr(8'h32, r[7:0]);
         rchk(8'h32, 8'h00);
         for (int i = 0; i < 3; i++) rchk(AZT_X_TRIM_ADDR + 8'(i), trim[i]);
         r = xs();
         if (n < 4) smp(cs[n], cs[n], cs[n]);
         else smp(r[13:0], r[27:14], ~r[13:0]);
      end
      // Reset in mid-run clears every trim
      @(posedge clk_sys);
      #1 rst = 1'b1;
      @(posedge clk_sys);
      #1 rst = 1'b0;
      trim = '{8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 3; i++) rchk(AZT_X_TRIM_ADDR + 8'(i), 8'h00);
      smp(14'sd8191, -14'sd8192, 14'sd7);
      tally_and_finish();
   end
endmodule
